// >>> include/dac_ctl_pkg.sv
/*
  constants for the transmit datapath control block: register offsets,
  field positions, reset values, power window limits.
  assumes 12-bit register addresses and 8-bit register data.

  // What this block does
  // - q coarse delay code 0..15, min to max
  // - arm bit rising write arms alignment
  // - mode 00 off, 10 key, 01 sysref
  // - key hit set only on data match
  // - ok bit set once alignment took effect
  // - error bit set on reset during rotation
  // - 16-bit i and q keys compared
  // - average above 13-bit limit trips protect
  // - power averaging only while enabled
  // - window is 2^(9+code) pairs, code 0..10
  // - power uses six sample msbs squared
  // - reading shows average until limit crossed
  // - bad k-character error forces gain off
  // - delay buffer error forces gain off
  // - lane fifo error forces gain off
  // - lane 0 config mismatch forces gain off
  // - code group, frame sync failures force off
  // - checksum failure forces gain off
  // - lane alignment failure forces gain off
  // - deskew failure forces gain off
  // - disparity count error forces gain off
  // - not-in-table count error forces gain off
*/
package dac_ctl_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  localparam logic [11:0] COARSE_DELAY_ADDR  = 12'h047;
  localparam logic [11:0] ALIGN_CTRL_ADDR    = 12'h050;
  localparam logic [11:0] KEY_I_LOW_ADDR     = 12'h051;
  localparam logic [11:0] KEY_I_HIGH_ADDR    = 12'h052;
  localparam logic [11:0] KEY_Q_LOW_ADDR     = 12'h053;
  localparam logic [11:0] KEY_Q_HIGH_ADDR    = 12'h054;
  localparam logic [11:0] LIMIT_LOW_ADDR     = 12'h060;
  localparam logic [11:0] LIMIT_HIGH_ADDR    = 12'h061;
  localparam logic [11:0] AVG_CONFIG_ADDR    = 12'h062;
  localparam logic [11:0] POWER_LOW_ADDR     = 12'h063;
  localparam logic [11:0] POWER_HIGH_ADDR    = 12'h064;
  localparam logic [11:0] GAIN_OFF_A_ADDR    = 12'h065;
  localparam logic [11:0] GAIN_OFF_B_ADDR    = 12'h066;

  localparam logic [7:0] COARSE_DELAY_RESET  = 8'h88;
  localparam logic [7:0] REG_RESET           = 8'h00;

  localparam int ARM_BIT      = 7;
  localparam int KEY_HIT_BIT  = 5;
  localparam int OK_BIT       = 4;
  localparam int ERROR_BIT    = 3;
  localparam int CALC_ON_BIT  = 7;
  localparam int KCHAR_BIT    = 7;
  localparam int DELAY_BUF_BIT = 1;
  localparam int LANE_FIFO_BIT = 0;

  localparam logic [1:0] MODE_OFF    = 2'b00;
  localparam logic [1:0] MODE_KEY    = 2'b10;
  localparam logic [1:0] MODE_SYSREF = 2'b01;

  localparam int          WINDOW_BASE_LOG2 = 9;
  localparam logic [3:0]  WINDOW_CODE_MAX  = 4'ha;
  localparam int          POWER_W          = 13;
  localparam int          MSB_USED         = 6;
  localparam int          ACC_W            = 32;
  localparam int          COUNT_W          = 20;

  typedef enum logic [1:0] {
    ALIGN_IDLE  = 2'b00,
    ALIGN_ARMED = 2'b01,
    ALIGN_DONE  = 2'b10
  } align_state_type;
endpackage

// >>> hw/dac_nco_align_power_protect.sv
/*
  control and status logic for the dual transmit datapath: q coarse
  group delay, oscillator phase alignment on data key or sysref,
  average power protection and gain-off selection on link errors.
  assumes one clock, synchronous inputs, a simple parallel register
  port, and link error levels produced by the link receiver.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_nco_align_power_protect
  import dac_ctl_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic [dac_ctl_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic [dac_ctl_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_rd,
  output logic      [dac_ctl_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                          sample_valid,
  input  wire logic [15:0]                   sample_i,
  input  wire logic [15:0]                   sample_q,
  input  wire logic                          sysref_pulse,
  input  wire logic                          rotate_reset,
  input  wire logic                          err_bad_kchar,
  input  wire logic                          err_delay_buf,
  input  wire logic                          err_lane_fifo,
  input  wire logic                          err_config_mismatch,
  input  wire logic                          err_codegroup,
  input  wire logic                          err_framesync,
  input  wire logic                          err_checksum,
  input  wire logic                          err_lane_align,
  input  wire logic                          err_deskew,
  input  wire logic                          err_disparity,
  input  wire logic                          err_not_in_table,
  output logic      [3:0]                    q_coarse_delay,
  output logic                               phase_align_strobe,
  output logic                               power_limit_tripped,
  output logic                               gain_off
);
  import dac_ctl_pkg::*;

  logic [7:0]        coarse_delay_q;
  logic              phase_align_arm_q;
  logic [1:0]        phase_align_select_q;
  logic [15:0]       align_key_i_q;
  logic [15:0]       align_key_q_q;
  logic [12:0]       power_limit_q;
  logic              power_calc_on_q;
  logic [3:0]        power_window_code_q;
  logic [7:0]        gain_off_en_a_q;
  logic [7:0]        gain_off_en_b_q;
  logic              phase_align_key_hit_q;
  logic              phase_align_ok_q;
  logic              phase_align_error_q;
  align_state_type   align_state_q;
  logic [ACC_W-1:0]  power_acc_q;
  logic [COUNT_W-1:0] power_count_q;
  logic [POWER_W-1:0] power_average_value_q;
  logic              arm_rise;
  logic              key_match;
  logic [3:0]        window_code;
  logic [4:0]        window_log2;
  logic [COUNT_W-1:0] window_last;
  logic [POWER_W-1:0] sample_power;
  logic [ACC_W-1:0]  acc_sum;
  logic [POWER_W-1:0] window_average;

  // square of the signed top six bits, magnitude first
  function automatic logic [11:0] msb_square(input logic [15:0] s);
    logic [MSB_USED-1:0] top;
    logic [MSB_USED-1:0] mag;
    top = s[15:10];
    mag = top[MSB_USED-1] ? 6'(-top) : top;
    return 12'(mag) * 12'(mag);
  endfunction

  function automatic logic wr_hit(input logic [11:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  assign arm_rise = wr_hit(ALIGN_CTRL_ADDR) && reg_wdata[ARM_BIT] && !phase_align_arm_q;

  assign key_match = sample_valid && (sample_i == align_key_i_q) && (sample_q == align_key_q_q);

  assign window_code = (power_window_code_q > WINDOW_CODE_MAX) ? WINDOW_CODE_MAX
                                                               : power_window_code_q;
  assign window_log2 = 5'(WINDOW_BASE_LOG2) + 5'(window_code);
  assign window_last = (COUNT_W'(1) << window_log2) - COUNT_W'(1);

  // six msbs squared, i plus q
  assign sample_power = 13'(msb_square(sample_i)) + 13'(msb_square(sample_q));
  assign acc_sum      = power_acc_q + ACC_W'(sample_power);
  assign window_average = POWER_W'(acc_sum >> window_log2);

  // configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      coarse_delay_q       <= COARSE_DELAY_RESET;
      phase_align_arm_q    <= 1'b0;
      phase_align_select_q <= MODE_OFF;
      align_key_i_q        <= '0;
      align_key_q_q        <= '0;
      power_limit_q        <= '0;
      power_calc_on_q      <= 1'b0;
      power_window_code_q  <= '0;
      gain_off_en_a_q      <= REG_RESET;
      gain_off_en_b_q      <= REG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == COARSE_DELAY_ADDR) begin
        coarse_delay_q <= reg_wdata;
      end else if (reg_addr == ALIGN_CTRL_ADDR) begin
        phase_align_arm_q    <= reg_wdata[ARM_BIT];
        phase_align_select_q <= reg_wdata[1:0];
      end else if (reg_addr == KEY_I_LOW_ADDR) begin
        align_key_i_q[7:0] <= reg_wdata;
      end else if (reg_addr == KEY_I_HIGH_ADDR) begin
        align_key_i_q[15:8] <= reg_wdata;
      end else if (reg_addr == KEY_Q_LOW_ADDR) begin
        align_key_q_q[7:0] <= reg_wdata;
      end else if (reg_addr == KEY_Q_HIGH_ADDR) begin
        align_key_q_q[15:8] <= reg_wdata;
      end else if (reg_addr == LIMIT_LOW_ADDR) begin
        power_limit_q[7:0] <= reg_wdata;
      end else if (reg_addr == LIMIT_HIGH_ADDR) begin
        power_limit_q[12:8] <= reg_wdata[4:0];
      end else if (reg_addr == AVG_CONFIG_ADDR) begin
        power_calc_on_q     <= reg_wdata[CALC_ON_BIT];
        power_window_code_q <= reg_wdata[3:0];
      end else if (reg_addr == GAIN_OFF_A_ADDR) begin
        gain_off_en_a_q <= reg_wdata;
      end else if (reg_addr == GAIN_OFF_B_ADDR) begin
        gain_off_en_b_q <= reg_wdata;
      end
    end
  end

  // q delay code, 0 min, 15 max
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_coarse_delay <= COARSE_DELAY_RESET[3:0];
    end else begin
      q_coarse_delay <= coarse_delay_q[3:0];
    end
  end

  // phase alignment sequence; a new arm clears status
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      align_state_q         <= ALIGN_IDLE;
      phase_align_key_hit_q <= 1'b0;
      phase_align_ok_q      <= 1'b0;
      phase_align_error_q   <= 1'b0;
      phase_align_strobe    <= 1'b0;
    end else begin
      phase_align_strobe <= 1'b0;
      case (align_state_q)
        ALIGN_IDLE, ALIGN_DONE: begin
          if (arm_rise) begin
            align_state_q         <= ALIGN_ARMED;
            phase_align_key_hit_q <= 1'b0;
            phase_align_ok_q      <= 1'b0;
            phase_align_error_q   <= 1'b0;
          end
        end
        ALIGN_ARMED: begin
          if (rotate_reset) begin
            phase_align_error_q <= 1'b1;
            align_state_q       <= ALIGN_DONE;
          end else if (phase_align_select_q == MODE_KEY && key_match) begin
            phase_align_key_hit_q <= 1'b1;
            phase_align_ok_q      <= 1'b1;
            phase_align_strobe    <= 1'b1;
            align_state_q         <= ALIGN_DONE;
          end else if (phase_align_select_q == MODE_SYSREF && sysref_pulse) begin
            phase_align_ok_q   <= 1'b1;
            phase_align_strobe <= 1'b1;
            align_state_q      <= ALIGN_DONE;
          end
        end
        default: begin
          align_state_q <= ALIGN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_acc_q   <= '0;
      power_count_q <= '0;
    end else if (!power_calc_on_q) begin
      power_acc_q   <= '0;
      power_count_q <= '0;
    end else if (sample_valid) begin
      if (power_count_q >= window_last) begin
        power_acc_q   <= '0;
        power_count_q <= '0;
      end else begin
        power_acc_q   <= acc_sum;
        power_count_q <= power_count_q + COUNT_W'(1);
      end
    end
  end

  // average result and protect flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_average_value_q <= '0;
      power_limit_tripped   <= 1'b0;
    end else if (!power_calc_on_q) begin
      power_limit_tripped <= 1'b0;
    end else if (sample_valid && power_count_q >= window_last && !power_limit_tripped) begin
      power_average_value_q <= window_average;
      if (window_average > power_limit_q) begin
        power_limit_tripped <= 1'b1;
      end
    end
  end

  // or of all enabled error conditions
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gain_off <= 1'b0;
    end else begin
      gain_off <=
        (gain_off_en_a_q[KCHAR_BIT] && err_bad_kchar) ||
        (gain_off_en_a_q[DELAY_BUF_BIT] && err_delay_buf) ||
        (gain_off_en_a_q[LANE_FIFO_BIT] && err_lane_fifo) ||
        (gain_off_en_b_q[7] && err_config_mismatch) ||
        (gain_off_en_b_q[6] && err_codegroup) ||
        (gain_off_en_b_q[5] && err_framesync) ||
        (gain_off_en_b_q[4] && err_checksum) ||
        (gain_off_en_b_q[3] && err_lane_align) ||
        (gain_off_en_b_q[2] && err_deskew) ||
        (gain_off_en_b_q[1] && err_disparity) ||
        (gain_off_en_b_q[0] && err_not_in_table);
    end
  end

  // read data, registered; unmapped reads return zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == COARSE_DELAY_ADDR) begin
        reg_rdata <= coarse_delay_q;
      end else if (reg_addr == ALIGN_CTRL_ADDR) begin
        reg_rdata <= {phase_align_arm_q, 1'b0, phase_align_key_hit_q, phase_align_ok_q,
                      phase_align_error_q, 1'b0, phase_align_select_q};
      end else if (reg_addr == KEY_I_LOW_ADDR) begin
        reg_rdata <= align_key_i_q[7:0];
      end else if (reg_addr == KEY_I_HIGH_ADDR) begin
        reg_rdata <= align_key_i_q[15:8];
      end else if (reg_addr == KEY_Q_LOW_ADDR) begin
        reg_rdata <= align_key_q_q[7:0];
      end else if (reg_addr == KEY_Q_HIGH_ADDR) begin
        reg_rdata <= align_key_q_q[15:8];
      end else if (reg_addr == LIMIT_LOW_ADDR) begin
        reg_rdata <= power_limit_q[7:0];
      end else if (reg_addr == LIMIT_HIGH_ADDR) begin
        reg_rdata <= {3'b000, power_limit_q[12:8]};
      end else if (reg_addr == AVG_CONFIG_ADDR) begin
        reg_rdata <= {power_calc_on_q, 3'b000, power_window_code_q};
      end else if (reg_addr == POWER_LOW_ADDR) begin
        reg_rdata <= power_average_value_q[7:0];
      end else if (reg_addr == POWER_HIGH_ADDR) begin
        reg_rdata <= {3'b000, power_average_value_q[12:8]};
      end else if (reg_addr == GAIN_OFF_A_ADDR) begin
        reg_rdata <= gain_off_en_a_q;
      end else if (reg_addr == GAIN_OFF_B_ADDR) begin
        reg_rdata <= gain_off_en_b_q;
      end else begin
        reg_rdata <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/iq_source.sv
/*
  far-side sample source: hands i/q pairs to the block, one per valid
  cycle, with optional idle cycles between them.
  assumes the caller waits for send to return before calling again.
*/
`timescale 1ns/1ps
`default_nettype none
module iq_source (
  input  wire logic        clk,
  output logic             sample_valid,
  output logic      [15:0] sample_i,
  output logic      [15:0] sample_q
);
  initial begin
    sample_valid = 1'b0;
    sample_i = 16'h0000;
    sample_q = 16'h0000;
  end
  // idle lines show the inverse so stale data never matches
  task automatic send(input int n, input logic [15:0] i, input logic [15:0] q,
                      input int gap);
    for (int k = 0; k < n; k++) begin
      @(posedge clk); #2;
      sample_valid = 1'b1;
      sample_i = i;
      sample_q = q;
      repeat (gap) begin
        @(posedge clk); #2;
        sample_valid = 1'b0;
        sample_i = ~i;
        sample_q = ~q;
      end
    end
    @(posedge clk); #2;
    sample_valid = 1'b0;
    sample_i = ~i;
    sample_q = ~q;
  endtask
endmodule
`default_nettype wire

// >>> sim/dac_ctl_checker.sv
/*
  port-level assertions for the datapath control block.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_ctl_checker
  import dac_ctl_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        sample_valid,
  input wire logic        sysref_pulse,
  input wire logic        err_bad_kchar,
  input wire logic        err_delay_buf,
  input wire logic        err_lane_fifo,
  input wire logic        err_config_mismatch,
  input wire logic        err_codegroup,
  input wire logic        err_framesync,
  input wire logic        err_checksum,
  input wire logic        err_lane_align,
  input wire logic        err_deskew,
  input wire logic        err_disparity,
  input wire logic        err_not_in_table,
  input wire logic [3:0]  q_coarse_delay,
  input wire logic        phase_align_strobe,
  input wire logic        power_limit_tripped,
  input wire logic        gain_off
);
  logic any_err;
  logic delay_wr;
  assign any_err = err_bad_kchar | err_delay_buf | err_lane_fifo | err_config_mismatch
    | err_codegroup | err_framesync | err_checksum | err_lane_align | err_deskew
    | err_disparity | err_not_in_table;
  assign delay_wr = reg_wr && reg_addr == COARSE_DELAY_ADDR;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_strobe_pulse;
    phase_align_strobe ##1 !phase_align_strobe;
  endsequence
  // output copy follows the stored register one cycle later
  a_delay_load: assert property (delay_wr |=> ##1 q_coarse_delay == $past(reg_wdata[3:0], 2))
    else $error("coarse delay not loaded");
  a_delay_hold: assert property (!delay_wr && !$past(delay_wr) |=> $stable(q_coarse_delay))
    else $error("coarse delay changed without write");
  a_strobe_single: assert property ($rose(phase_align_strobe) |-> s_strobe_pulse)
    else $error("align strobe not one cycle");
  a_strobe_cause: assert property (phase_align_strobe |-> $past(sample_valid | sysref_pulse))
    else $error("align strobe without trigger");
  a_trip_cause: assert property ($rose(power_limit_tripped) |-> $past(sample_valid))
    else $error("protect set without sample");
  a_gain_follow: assert property (gain_off |-> $past(any_err))
    else $error("gain off without error");
  a_gain_clear: assert property (!any_err |=> !gain_off)
    else $error("gain off stuck");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (reg_rd && reg_addr > GAIN_OFF_B_ADDR |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind dac_nco_align_power_protect dac_ctl_checker u_dac_ctl_checker (.*);
`default_nettype wire

// >>> sim/dac_nco_align_power_protect_test.sv
/*
  self-checking bench for the datapath control block.
  assumes iq_source as sample source and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_nco_align_power_protect_test;
  import dac_ctl_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic sysref_pulse = 1'b0, rotate_reset = 1'b0, sample_valid, phase_align_strobe;
  logic power_limit_tripped, gain_off;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [15:0] sample_i, sample_q;
  logic [10:0] errs = 11'h000;
  logic [3:0] q_coarse_delay;
  int num_errors = 0, checks_done = 0, cycles = 0, strobes = 0;
  int pos[11] = '{15, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0};
  always #12.5 clk = ~clk;
  iq_source u_iq_source (.clk(clk), .sample_valid(sample_valid), .sample_i(sample_i),
    .sample_q(sample_q));
  dac_nco_align_power_protect u_dac_nco_align_power_protect (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_i(sample_i),
    .sample_q(sample_q), .sysref_pulse(sysref_pulse), .rotate_reset(rotate_reset),
    .err_bad_kchar(errs[0]), .err_delay_buf(errs[1]), .err_lane_fifo(errs[2]),
    .err_config_mismatch(errs[3]), .err_codegroup(errs[4]), .err_framesync(errs[5]),
    .err_checksum(errs[6]), .err_lane_align(errs[7]), .err_deskew(errs[8]),
    .err_disparity(errs[9]), .err_not_in_table(errs[10]), .q_coarse_delay(q_coarse_delay),
    .phase_align_strobe(phase_align_strobe), .power_limit_tripped(power_limit_tripped),
    .gain_off(gain_off));
  always @(posedge clk) begin
    cycles++;
    if (phase_align_strobe === 1'b1) strobes++;
    if (cycles == 20000) begin
      num_errors++;
      $display("Error at %0t: run did not finish in time", $time);
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk); #2;
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(posedge clk); #2;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk); #2;
    reg_rd = 1'b1; reg_addr = a;
    @(posedge clk); #2;
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  task automatic pulse(input bit rot);
    @(posedge clk); #2;
    if (rot) rotate_reset = 1'b1; else sysref_pulse = 1'b1;
    @(posedge clk); #2;
    rotate_reset = 1'b0; sysref_pulse = 1'b0;
  endtask
  task automatic test_reset_map;
    chk(q_coarse_delay, 4'h8);
    rd(COARSE_DELAY_ADDR, 8'h88);
    for (int a = 12'h04f; a <= 12'h067; a++) rd(a[11:0], 8'h00);
    wr(COARSE_DELAY_ADDR, 8'h0f); rd(COARSE_DELAY_ADDR, 8'h0f); chk(q_coarse_delay, 4'hf);
    wr(COARSE_DELAY_ADDR, 8'h30);
    @(posedge clk); #2;
    chk(q_coarse_delay, 4'h0);
    wr(LIMIT_HIGH_ADDR, 8'hff); rd(LIMIT_HIGH_ADDR, 8'h1f);
    wr(AVG_CONFIG_ADDR, 8'hff); rd(AVG_CONFIG_ADDR, 8'h8f); wr(AVG_CONFIG_ADDR, 8'h00);
    wr(POWER_LOW_ADDR, 8'hff); rd(POWER_LOW_ADDR, 8'h00);
    wr(GAIN_OFF_A_ADDR, 8'hff); rd(GAIN_OFF_A_ADDR, 8'hff);
    wr(12'h070, 8'hff); rd(12'h070, 8'h00);
  endtask
  task automatic test_key_align;
    wr(KEY_I_LOW_ADDR, 8'h34); wr(KEY_I_HIGH_ADDR, 8'h12);
    wr(KEY_Q_LOW_ADDR, 8'hcd); wr(KEY_Q_HIGH_ADDR, 8'hab);
    rd(KEY_Q_HIGH_ADDR, 8'hab);
    wr(ALIGN_CTRL_ADDR, 8'h82);
    u_iq_source.send(1, 16'h1234, 16'habcc, 1);
    rd(ALIGN_CTRL_ADDR, 8'h82); chk(strobes, 0);
    u_iq_source.send(1, 16'h1234, 16'habcd, 2);
    rd(ALIGN_CTRL_ADDR, 8'hb2); chk(strobes, 1);
    wr(ALIGN_CTRL_ADDR, 8'h82); rd(ALIGN_CTRL_ADDR, 8'hb2);
  endtask
  task automatic test_sysref_align;
    wr(ALIGN_CTRL_ADDR, 8'h01); wr(ALIGN_CTRL_ADDR, 8'h81);
    pulse(0); rd(ALIGN_CTRL_ADDR, 8'h91); chk(strobes, 2);
    wr(ALIGN_CTRL_ADDR, 8'h01); wr(ALIGN_CTRL_ADDR, 8'h81); rd(ALIGN_CTRL_ADDR, 8'h81);
    pulse(1); rd(ALIGN_CTRL_ADDR, 8'h89);
    wr(ALIGN_CTRL_ADDR, 8'h00); wr(ALIGN_CTRL_ADDR, 8'h80);
    pulse(0); u_iq_source.send(1, 16'h1234, 16'habcd, 0);
    rd(ALIGN_CTRL_ADDR, 8'h80); chk(strobes, 2);
  endtask
  task automatic test_power;
    wr(LIMIT_LOW_ADDR, 8'hff); wr(LIMIT_HIGH_ADDR, 8'h1f); wr(AVG_CONFIG_ADDR, 8'h81);
    u_iq_source.send(512, 16'h7c00, 16'h83ff, 0);
    rd(POWER_LOW_ADDR, 8'h00);
    u_iq_source.send(512, 16'h7c00, 16'h83ff, 0);
    rd(POWER_LOW_ADDR, 8'hc1); rd(POWER_HIGH_ADDR, 8'h07);
    chk(power_limit_tripped, 1'b0);
    wr(LIMIT_LOW_ADDR, 8'hc0); wr(LIMIT_HIGH_ADDR, 8'h07);
    wr(AVG_CONFIG_ADDR, 8'h00); wr(AVG_CONFIG_ADDR, 8'h80);
    u_iq_source.send(512, 16'h7c00, 16'h83ff, 0);
    chk(power_limit_tripped, 1'b1);
    // a quiet window after the trip must not replace the reading
    u_iq_source.send(512, 16'h0000, 16'h0000, 0);
    rd(POWER_LOW_ADDR, 8'hc1);
    chk(power_limit_tripped, 1'b1);
    wr(AVG_CONFIG_ADDR, 8'h00);
    u_iq_source.send(512, 16'h7c00, 16'h83ff, 0);
    chk(power_limit_tripped, 1'b0);
  endtask
  task automatic test_gain_off;
    for (int i = 0; i < 11; i++) begin
      logic [15:0] m;
      m = 16'h0001 << pos[i];
      wr(GAIN_OFF_A_ADDR, ~m[15:8]); wr(GAIN_OFF_B_ADDR, ~m[7:0]);
      errs = 11'h001 << i;
      repeat (2) @(posedge clk); #2;
      chk(gain_off, 1'b0);
      wr(GAIN_OFF_A_ADDR, m[15:8]); wr(GAIN_OFF_B_ADDR, m[7:0]);
      @(posedge clk); #2;
      chk(gain_off, 1'b1);
      errs = 11'h000;
      @(posedge clk); #2;
      chk(gain_off, 1'b0);
    end
  endtask
  task automatic conclude;
    $display("checks_done %0d num_errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #2 reset_n = 1'b1;
    test_reset_map();
    test_key_align();
    test_sysref_align();
    test_power();
    test_gain_off();
    conclude();
  end
endmodule
`default_nettype wire
